// ### common/sif_pkg.sv
// How it works
// RL1 - reported state follows commanded state within three heartbeat ticks
// RL2 - state codes: 000 sleep, 001 standby, 010 watch, 101 wake, 110 combined, 111 burst
// RL3 - watch state does no buffer work, moves to wake on activity
// RL4 - burst takes 1 to 254 samples or runs on, then returns to sleep
// RL5 - new-sample bit 3 sets on every fresh sample, regardless of enables
// RL6 - buffer-empty bit 4 is a level, one after reset
// RL7 - threshold bit 6 is high while count is at or above threshold
// RL8 - pending bit 7 is the OR of all pending flags
// RL9 - a pending flag sets only when its enable bit is one
// RL10 - flags clear on read under I2C by default, else on write
// RL11 - wake flag sets on each automatic watch-to-wake move
// RL12 - acquisition flag sets on new sample in wake or burst states
// RL13 - empty flag sets on empty edge, needs non-empty then empty again
// RL14 - full flag sets when 32 stored, needs full to drop and return
// RL15 - threshold flag sets on each cycle count is at or above the threshold, holds until cleared with count below it
// RL16 - combined flag sets only in combined state, detector then blocked
// RL17 - with re-arm option set, clearing combined flag resets the detector
// RL18 - reserved low bits read zero, state register read clears new-sample bit
package sif_pkg;
  localparam logic [7:0] SIF_OFS_STATE = 8'h08;
  localparam logic [7:0] SIF_OFS_PEND = 8'h09;
  localparam int SIF_BIT_NEW = 3;
  localparam int SIF_BIT_EMPTY = 4;
  localparam int SIF_BIT_FULL = 5;
  localparam int SIF_BIT_THR = 6;
  localparam int SIF_BIT_ANY = 7;
  localparam int SIF_IRQ_WAKE = 2;
  localparam int SIF_IRQ_ACQ = 3;
  localparam int SIF_IRQ_EMPTY = 4;
  localparam int SIF_IRQ_FULL = 5;
  localparam int SIF_IRQ_THR = 6;
  localparam int SIF_IRQ_COMB = 7;
  localparam logic [7:0] SIF_RST_STATE = 8'h00;
  localparam logic [7:0] SIF_RST_PEND = 8'h00;
  localparam logic [5:0] SIF_FULL_COUNT = 6'h20;
  localparam logic [7:0] SIF_BURST_MAX = 8'hFE;
  localparam logic [1:0] SIF_LAG_TICKS = 2'h3;
  typedef enum logic [2:0] {
    SIF_SLEEP = 3'h0,
    SIF_STANDBY = 3'h1,
    SIF_WATCH = 3'h2,
    SIF_WAKE = 3'h5,
    SIF_COMB = 3'h6,
    SIF_BURST = 3'h7
  } sif_state_e;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
  } sif_acc_s;
  typedef struct packed {
    logic new_sample;
    logic activity;
    logic [5:0] count;
    logic [4:0] thresh;
  } sif_evt_s;
endpackage

// ### hw/sif_lag.sv
`timescale 1ns/1ns
`default_nettype none
module sif_lag
  import sif_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic beat_i,
  input wire logic [2:0] cmd_i,
  input wire logic [2:0] auto_i,
  input wire logic auto_load_i,
  output logic [2:0] state_o
);
  logic [1:0] cnt_ff;
  logic [2:0] pend_ff;
  logic busy_ff;
  wire logic take = busy_ff && beat_i && (cnt_ff == SIF_LAG_TICKS - 2'h1);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 2'h0;
      pend_ff <= 3'h0;
      busy_ff <= 1'b0;
      state_o <= 3'h0;
    end else if (auto_load_i) begin
      state_o <= auto_i;
      busy_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (cmd_i != pend_ff) begin
      pend_ff <= cmd_i;
      busy_ff <= 1'b1;
      cnt_ff <= 2'h0;
    end else if (take) begin
      state_o <= pend_ff; // RL1
      busy_ff <= 1'b0;
    end else if (busy_ff && beat_i) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule // sif_lag
`default_nettype wire

// ### hw/sif_edge.sv
`timescale 1ns/1ns
`default_nettype none
module sif_edge (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic lvl_i,
  input wire logic rst_val_i,
  output logic rise_o
);
  logic last_ff;
  logic init_ff;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_ff <= 1'b0;
      init_ff <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      init_ff <= 1'b1;
      last_ff <= lvl_i;
      rise_o <= lvl_i && (init_ff ? !last_ff : !rst_val_i);
    end
  end
endmodule // sif_edge
`default_nettype wire

// ### hw/sif_top.sv
`timescale 1ns/1ns
`default_nettype none
module sif_top
  import sif_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic beat_i,
  input wire sif_acc_s acc_i,
  input wire sif_evt_s evt_i,
  input wire logic [2:0] cmd_state_i,
  input wire logic [7:0] burst_len_i,
  input wire logic [7:0] irq_en_i,
  input wire logic i2c_sel_i,
  input wire logic wr_clear_sel_i,
  input wire logic rearm_sel_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] state_reg_o,
  output logic [7:0] pend_reg_o,
  output logic [2:0] run_state_o,
  output logic buffer_hold_o,
  output logic detect_armed_o
);
  // ***********************************
  // state tracking
  // ***********************************
  logic [2:0] rep_state;
  logic [7:0] burst_cnt_ff;
  logic new_ff;
  logic [7:0] pend_ff;
  logic armed_ff;
  wire logic in_watch = rep_state == SIF_WATCH;
  wire logic in_comb = rep_state == SIF_COMB;
  wire logic in_burst = rep_state == SIF_BURST;
  wire logic in_wake = rep_state == SIF_WAKE;
  wire logic to_wake = in_watch && evt_i.activity; // RL3
  wire logic burst_done = in_burst && evt_i.new_sample && (burst_len_i != 8'h00) &&
    (burst_cnt_ff + 8'h01 >= burst_len_i) && (burst_len_i <= SIF_BURST_MAX); // RL4
  wire logic auto_load = to_wake || burst_done;
  wire logic [2:0] auto_st = to_wake ? SIF_WAKE : SIF_SLEEP;
  sif_lag u_lag (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .beat_i(beat_i),
    .cmd_i(cmd_state_i),
    .auto_i(auto_st),
    .auto_load_i(auto_load),
    .state_o(rep_state)
  );
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      burst_cnt_ff <= 8'h00;
    end else if (!in_burst || burst_done) begin
      burst_cnt_ff <= 8'h00;
    end else if (evt_i.new_sample) begin
      burst_cnt_ff <= burst_cnt_ff + 8'h01; // RL4
    end
  end
  // ***********************************
  // levels and edges
  // ***********************************
  wire logic lv_empty = evt_i.count == 6'h00; // RL6
  wire logic lv_full = evt_i.count >= SIF_FULL_COUNT;
  wire logic lv_thr = evt_i.count >= {1'b0, evt_i.thresh}; // RL7
  logic empty_rise;
  logic full_rise;
  sif_edge u_empty (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .lvl_i(lv_empty),
    .rst_val_i(1'b1),
    .rise_o(empty_rise)
  );
  sif_edge u_full (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .lvl_i(lv_full),
    .rst_val_i(1'b0),
    .rise_o(full_rise)
  );
  // ***********************************
  // access decode
  // ***********************************
  wire logic rd_state = acc_i.rd && acc_i.addr == SIF_OFS_STATE;
  wire logic rd_pend = acc_i.rd && acc_i.addr == SIF_OFS_PEND;
  wire logic wr_pend = acc_i.wr && acc_i.addr == SIF_OFS_PEND;
  wire logic clr_pend = (i2c_sel_i && !wr_clear_sel_i) ? rd_pend : wr_pend; // RL10
  wire logic comb_evt = in_comb && evt_i.activity && armed_ff; // RL16
  // ***********************************
  // sticky flags
  // ***********************************
  logic [7:0] raw_set;
  assign raw_set[1:0] = 2'b00; // RL18
  assign raw_set[SIF_IRQ_WAKE] = to_wake; // RL11
  assign raw_set[SIF_IRQ_ACQ] = evt_i.new_sample && (in_wake || in_burst); // RL12
  assign raw_set[SIF_IRQ_EMPTY] = empty_rise; // RL13
  assign raw_set[SIF_IRQ_FULL] = full_rise; // RL14
  assign raw_set[SIF_IRQ_THR] = lv_thr; // RL15
  assign raw_set[SIF_IRQ_COMB] = comb_evt; // RL16
  wire logic [7:0] set_v = raw_set & irq_en_i & 8'hFC; // RL9
  wire logic [7:0] nxt_pend = (clr_pend ? 8'h00 : pend_ff) | set_v;
  wire logic nxt_new = evt_i.new_sample || (new_ff && !rd_state); // RL5
  wire logic [7:0] state_v = {|pend_ff, lv_thr, lv_full, lv_empty, new_ff, rep_state}; // RL8
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_ff <= SIF_RST_PEND;
      new_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      new_ff <= nxt_new; // RL18
    end
  end
  // ***********************************
  // detector arming
  // ***********************************
  wire logic comb_clr = clr_pend && pend_ff[SIF_IRQ_COMB] && !set_v[SIF_IRQ_COMB];
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed_ff <= 1'b1;
    end else if (!in_comb) begin
      armed_ff <= 1'b1;
    end else if (comb_evt) begin
      armed_ff <= 1'b0; // RL16
    end else if (comb_clr && rearm_sel_i) begin
      armed_ff <= 1'b1; // RL17
    end
  end
  // ***********************************
  // outputs
  // ***********************************
  wire logic [7:0] rd_v = rd_state ? state_v : (rd_pend ? pend_ff : 8'h00);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= 8'h00;
      state_reg_o <= 8'h10;
      pend_reg_o <= SIF_RST_PEND;
      run_state_o <= 3'h0;
      buffer_hold_o <= 1'b1;
      detect_armed_o <= 1'b1;
    end else begin
      rd_data_o <= rd_v;
      state_reg_o <= state_v;
      pend_reg_o <= pend_ff;
      run_state_o <= rep_state;
      buffer_hold_o <= in_watch; // RL3
      detect_armed_o <= armed_ff;
    end
  end
  // ***********************************
  // checks
  // ***********************************
  any_or_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 state_reg_o[SIF_BIT_ANY] == |$past(pend_ff)) else $error("pending or wrong"); // RL8
  low_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pend_ff[1:0] == 2'b00) else $error("reserved bits set"); // RL18
  en_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(pend_ff[SIF_IRQ_THR]) |-> $past(irq_en_i[SIF_IRQ_THR])) else $error("set unenabled"); // RL9
  sequence clr_seq;
    clr_pend && !set_v[SIF_IRQ_WAKE];
  endsequence
  clr_work_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    clr_seq |=> !pend_ff[SIF_IRQ_WAKE]) else $error("clear failed"); // RL10
  wake_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    to_wake && irq_en_i[SIF_IRQ_WAKE] |=> pend_ff[SIF_IRQ_WAKE]) else $error("wake lost"); // RL11
  new_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    evt_i.new_sample |=> new_ff) else $error("new sample lost"); // RL5
  empty_lvl_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 state_reg_o[SIF_BIT_EMPTY] == $past(lv_empty)) else $error("empty level wrong"); // RL6
  comb_only_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(pend_ff[SIF_IRQ_COMB]) |-> $past(in_comb)) else $error("combined outside state"); // RL16
endmodule // sif_top
`default_nettype wire

// ### tb/sif_host.sv
`timescale 1ns/1ns
`default_nettype none
module sif_host
  import sif_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [7:0] rd_data_i,
  output sif_acc_s acc_o
);
  initial acc_o = '0;
  // one-cycle strobe; read data is taken in the cycle after the strobe
  task automatic xfer(input logic w, input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    acc_o = '{rd: !w, wr: w, addr: a};
    @(negedge clk_sys_i);
    d = rd_data_i;
    acc_o = '0;
  endtask
endmodule // sif_host
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import sif_pkg::*;
;
  logic clk_sys_i = 0, rstn_i = 0, beat_i = 0, i2c_sel_i = 1;
  logic wr_clear_sel_i = 0, rearm_sel_i = 0;
  sif_evt_s evt_i = '0;
  sif_acc_s acc_i;
  logic [2:0] cmd_state_i = 3'h0, run_state_o, m_mode = 3'h0;
  logic [7:0] burst_len_i = 8'h00, irq_en_i = 8'hFC, rd_data_o, state_reg_o, pend_reg_o, d;
  logic [7:0] exp_pend = 8'h00;
  logic buffer_hold_o, detect_armed_o, m_new = 0;
  int fail_count = 0, tests_run = 0, t, cnt = 0;
  sif_state_e codes[6] = '{SIF_STANDBY, SIF_WAKE, SIF_BURST, SIF_COMB, SIF_SLEEP, SIF_WATCH};
  initial forever #10 clk_sys_i = !clk_sys_i;
  sif_host u_sif_host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data_o), .acc_o(acc_i));
  sif_top u_sif_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .beat_i(beat_i), .acc_i(acc_i),
    .evt_i(evt_i), .cmd_state_i(cmd_state_i), .burst_len_i(burst_len_i), .irq_en_i(irq_en_i),
    .i2c_sel_i(i2c_sel_i), .wr_clear_sel_i(wr_clear_sel_i), .rearm_sel_i(rearm_sel_i),
    .rd_data_o(rd_data_o),
    .state_reg_o(state_reg_o), .pend_reg_o(pend_reg_o), .run_state_o(run_state_o),
    .buffer_hold_o(buffer_hold_o), .detect_armed_o(detect_armed_o));
  // ****************************************
  // model and helpers
  // ****************************************
  function automatic logic [7:0] exp_st();
    return {exp_pend != 0, cnt >= t, cnt == 32, cnt == 0, m_new, m_mode};
  endfunction
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic beats();
    repeat (3) begin
      @(negedge clk_sys_i) beat_i = 1;
      @(negedge clk_sys_i) beat_i = 0;
    end
    cyc(2);
  endtask
  task automatic pulse(input logic act);
    @(negedge clk_sys_i);
    if (act) evt_i.activity = 1;
    else evt_i.new_sample = 1;
    @(negedge clk_sys_i);
    evt_i.activity = 0;
    evt_i.new_sample = 0;
  endtask
  task automatic wait_pend(input int b);
    for (int i = 0; i < 8 && pend_reg_o[b] !== 1'b1; i++) @(negedge clk_sys_i);
    if (pend_reg_o[b] !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask
  task automatic set_cnt(input int c, input int b);
    cnt = c;
    evt_i.count = 6'(c);
    wait_pend(b);
    exp_pend[b] = 1;
    check("pend", pend_reg_o, exp_pend);
    check("state", state_reg_o, exp_st());
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    final_report();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(24339));
    t = $urandom_range(30, 2);
    evt_i.thresh = 5'(t);
    cyc(12);
    check("st_rst", state_reg_o, exp_st());
    check("pend_rst", pend_reg_o, SIF_RST_PEND);
    rstn_i = 1;
    foreach (codes[i]) begin
      cmd_state_i = codes[i];
      beats();
      check("run", {5'h00, run_state_o}, {5'h00, codes[i]});
    end
    check("hold", {7'h00, buffer_hold_o}, 8'h01);
    irq_en_i = 8'h00;
    pulse(1);
    cyc(3);
    check("run_auto", {5'h00, run_state_o}, {5'h00, SIF_WAKE});
    check("no_en", pend_reg_o, 8'h00);
    cmd_state_i = SIF_STANDBY;
    beats();
    cmd_state_i = SIF_WATCH;
    beats();
    irq_en_i = 8'hFC;
    pulse(1);
    wait_pend(SIF_IRQ_WAKE);
    m_mode = SIF_WAKE;
    exp_pend = 8'h04;
    check("wake", pend_reg_o, exp_pend);
    check("any", state_reg_o, exp_st());
    u_sif_host.xfer(0, SIF_OFS_PEND, d);
    check("rd_pend", d, exp_pend);
    exp_pend = 8'h00;
    cyc(2);
    check("rd_clr", pend_reg_o, exp_pend);
    pulse(0);
    wait_pend(SIF_IRQ_ACQ);
    exp_pend = 8'h08;
    m_new = 1;
    check("acq", pend_reg_o, exp_pend);
    u_sif_host.xfer(0, SIF_OFS_STATE, d);
    check("rd_st", d, exp_st());
    m_new = 0;
    i2c_sel_i = 0;
    u_sif_host.xfer(1, SIF_OFS_PEND, d);
    exp_pend = 8'h00;
    cyc(2);
    check("wr_clr", pend_reg_o, exp_pend);
    check("new_clr", state_reg_o, exp_st());
    cnt = t - 1;
    evt_i.count = 6'(cnt);
    cyc(3);
    check("below", state_reg_o, exp_st());
    set_cnt(t, SIF_IRQ_THR);
    set_cnt(32, SIF_IRQ_FULL);
    set_cnt(0, SIF_IRQ_EMPTY);
    u_sif_host.xfer(1, SIF_OFS_PEND, d);
    exp_pend = 8'h00;
    cyc(4);
    check("no_retrig", pend_reg_o, exp_pend);
    cmd_state_i = SIF_COMB;
    beats();
    pulse(1);
    wait_pend(SIF_IRQ_COMB);
    exp_pend = 8'h80;
    check("comb", pend_reg_o, exp_pend);
    check("disarm", {7'h00, detect_armed_o}, 8'h00);
    i2c_sel_i = 1;
    wr_clear_sel_i = 1;
    rearm_sel_i = 1;
    u_sif_host.xfer(0, SIF_OFS_PEND, d);
    cyc(2);
    check("rd_keep", pend_reg_o, exp_pend);
    u_sif_host.xfer(1, SIF_OFS_PEND, d);
    exp_pend = 8'h00;
    cyc(2);
    check("i2c_wr_clr", pend_reg_o, exp_pend);
    check("rearm", {7'h00, detect_armed_o}, 8'h01);
    pulse(1);
    wait_pend(SIF_IRQ_COMB);
    exp_pend = 8'h80;
    check("refire", pend_reg_o, exp_pend);
    rearm_sel_i = 0;
    u_sif_host.xfer(1, SIF_OFS_PEND, d);
    exp_pend = 8'h00;
    cyc(2);
    check("no_rearm", {7'h00, detect_armed_o}, 8'h00);
    pulse(1);
    cyc(3);
    check("blocked", pend_reg_o, exp_pend);
    burst_len_i = 8'h02;
    cmd_state_i = SIF_BURST;
    beats();
    pulse(0);
    pulse(0);
    cyc(3);
    check("burst_end", {5'h00, run_state_o}, {5'h00, SIF_SLEEP});
    final_report();
  end
endmodule // tb_top
`default_nettype wire
